// file: logic/acps_seq_regs.vh
`ifndef ACPS_SEQ_REGS_VH
`define ACPS_SEQ_REGS_VH

// Clock rate in kHz
`define ACPS_CLK_KHZ        10000
// PLL lock waits in ms and cycles
`define ACPS_LOCK_BCK_MS    2
`define ACPS_LOCK_MCK_MS    10
// Sized to the counter so no bits are dropped at the limit port
`define ACPS_LOCK_BCK_CYC   20'h04E20
`define ACPS_LOCK_MCK_CYC   20'h186A0
// ADC initialisation length in frames (adc_init_cycle_select = 00)
`define ACPS_INIT_FRAMES    20'h00423
`define ACPS_INIT_SEL_STD   2'h0
// Clock mode codes
`define ACPS_MODE_PLL_MST   2'h0
`define ACPS_MODE_PLL_BCK   2'h1
`define ACPS_MODE_PLL_MCK   2'h2
`define ACPS_MODE_EXT       2'h3
// Reset values
`define ACPS_VOL_RST        8'h91
`define ACPS_CNT_W          20
`define ACPS_CNT_RST        20'h00000

`endif

// file: logic/acps_wait_counter.v
`timescale 1ns/100ps
`include "acps_seq_regs.vh"
module acps_wait_counter (
    input  wire                    ref_clk,
    input  wire                    resetn,
    input  wire                    clkEn,
    input  wire                    start,
    input  wire                    tick,
    input  wire [`ACPS_CNT_W-1:0]  limit,
    output reg                     done
);
    reg [`ACPS_CNT_W-1:0] count;
    reg                   running;

    always @(posedge ref_clk) begin
        if (!resetn) begin
            count   <= `ACPS_CNT_RST;
            running <= 1'b0;
            done    <= 1'b0;
        end else if (clkEn) begin
            if (start) begin
                count   <= `ACPS_CNT_RST;
                running <= 1'b1;
                done    <= 1'b0;
            end else if (running && tick) begin
                if (count == limit - 20'h00001) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end
                count <= count + 20'h00001;
            end
        end
    end
endmodule // acps_wait_counter

// file: logic/acps_seq.v
`timescale 1ns/100ps
`include "acps_seq_regs.vh"
// Functional notes
// - Bit-clock PLL starts on power, locks 2ms; the code starts it only if the bit clock is present at the power-on edge.
// - Master-clock PLL starts on power, locks 10ms; the code starts it only if the master clock is present at the power-on edge.
// - Master clock output valid only after lock.
// - External slave runs once all clocks present.
// - Master select drives frame and bit clocks; external mode only here, PLL master mode drives them once locked.
// - ADC power-up: 1059 frames of zero output.
// - Level control starts from initial volume.
// - Reset low returns all controls to default.
module acps_seq (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire        clkEn,
    input  wire [1:0]  clockMode,
    input  wire        masterSelect,
    input  wire        commonRefPower,
    input  wire        pllPower,
    input  wire        masterClockOutEnable,
    input  wire        adcLeftPower,
    input  wire        adcRightPower,
    input  wire [1:0]  adcInitCycleSelect,
    input  wire        levelControlAEnable,
    input  wire [7:0]  initialVolume,
    input  wire        masterClockPresent,
    input  wire        bitClockPresent,
    input  wire        frameClockPresent,
    input  wire        frameTick,
    output reg         pllLocked,
    output reg         masterClockOutValid,
    output reg         clocksOutEnable,
    output reg         normalOperation,
    output reg         adcInitBusy,
    output reg         adcDataZero,
    output reg         levelActive,
    output reg  [7:0]  levelGain
);
    ////////////////////////////////////////////////////////////////
    localparam ST_OFF  = 2'h0;
    localparam ST_LOCK = 2'h1;
    localparam ST_RUN  = 2'h2;

    reg  [1:0]  pllState;
    reg  [1:0]  next_pllState;
    reg         pllPowerQ;
    reg         adcPowerQ;
    reg         levelEnQ;
    wire        adcPower = adcLeftPower & adcRightPower;
    wire        pllMode  = (clockMode != `ACPS_MODE_EXT);
    wire        refPresent = (clockMode == `ACPS_MODE_PLL_BCK) ?
                             bitClockPresent : masterClockPresent;
    wire [`ACPS_CNT_W-1:0] lockLimit =
        (clockMode == `ACPS_MODE_PLL_BCK) ?
        `ACPS_LOCK_BCK_CYC : `ACPS_LOCK_MCK_CYC;
    wire        lockStart = (pllState == ST_OFF) && (next_pllState == ST_LOCK);
    wire        lockDone;
    wire        initStart = adcPower && !adcPowerQ;
    wire        initDone;

    ////////////////////////////////////////////////////////////////
    // Lock wait counter; lock time is the worst-case figure
    acps_wait_counter uLock (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clkEn   (clkEn),
        .start   (lockStart),
        .tick    (1'b1),
        .limit   (lockLimit),
        .done    (lockDone)
    );

    // Only the standard init length is modelled
    acps_wait_counter uInit (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clkEn   (clkEn),
        .start   (initStart),
        .tick    (frameTick),
        .limit   (`ACPS_INIT_FRAMES),
        .done    (initDone)
    );

    ////////////////////////////////////////////////////////////////
    always @* begin
        next_pllState = pllState;
        case (pllState)
            ST_OFF:
                if (pllMode && pllPower && !pllPowerQ && refPresent)
                    next_pllState = ST_LOCK;
            ST_LOCK:
                if (!pllPower || !pllMode)
                    next_pllState = ST_OFF;
                else if (lockDone && !lockStart)
                    next_pllState = ST_RUN;
            ST_RUN:
                if (!pllPower || !pllMode || !refPresent)
                    next_pllState = ST_OFF;
            default:
                next_pllState = ST_OFF;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // PLL state and edge detectors
    always @(posedge ref_clk) begin
        if (!resetn) begin
            pllState  <= ST_OFF;
            pllPowerQ <= 1'b0;
            adcPowerQ <= 1'b0;
            levelEnQ  <= 1'b0;
        end else if (clkEn) begin
            pllState  <= next_pllState;
            // Edge detect so a held bit does not retrigger the PLL
            pllPowerQ <= pllPower;
            adcPowerQ <= adcPower;
            levelEnQ  <= levelControlAEnable;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Clock outputs
    wire        extMasterClocks = masterSelect &&
                (clockMode == `ACPS_MODE_EXT) && masterClockPresent;
    wire        pllMasterClocks = (clockMode == `ACPS_MODE_PLL_MST) &&
                (next_pllState == ST_RUN);
    wire        mclkOutMode = (clockMode == `ACPS_MODE_PLL_MST) ||
                (clockMode == `ACPS_MODE_PLL_MCK);

    always @(posedge ref_clk) begin
        if (!resetn) begin
            pllLocked           <= 1'b0;
            masterClockOutValid <= 1'b0;
            clocksOutEnable     <= 1'b0;
        end else if (clkEn) begin
            pllLocked <= (next_pllState == ST_RUN);
            // Invalid frequency before lock is masked here
            masterClockOutValid <= masterClockOutEnable && mclkOutMode &&
                (next_pllState == ST_RUN);
            clocksOutEnable <= extMasterClocks || pllMasterClocks;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Normal operation flag
    always @(posedge ref_clk) begin
        if (!resetn) begin
            normalOperation <= 1'b0;
        end else if (clkEn) begin
            if (clockMode == `ACPS_MODE_EXT)
                normalOperation <= commonRefPower && masterClockPresent &&
                    (masterSelect ||
                     (frameClockPresent && bitClockPresent));
            else
                normalOperation <= commonRefPower &&
                    (next_pllState == ST_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////
    // ADC initialisation; dropping either power aborts it
    always @(posedge ref_clk) begin
        if (!resetn) begin
            adcInitBusy <= 1'b0;
            adcDataZero <= 1'b1;
        end else if (clkEn) begin
            if (!adcPower) begin
                adcInitBusy <= 1'b0;
                adcDataZero <= 1'b1;
            end else if (initStart) begin
                adcInitBusy <= 1'b1;
                adcDataZero <= 1'b1;
            end else if (initDone && adcInitBusy) begin
                adcInitBusy <= 1'b0;
                adcDataZero <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Level control start
    always @(posedge ref_clk) begin
        if (!resetn) begin
            levelActive <= 1'b0;
            levelGain   <= `ACPS_VOL_RST;
        end else if (clkEn) begin
            if (levelControlAEnable && !levelEnQ) begin
                levelActive <= 1'b1;
                levelGain   <= initialVolume;
            end else if (!levelControlAEnable) begin
                levelActive <= 1'b0;
            end
        end
    end
endmodule // acps_seq

// file: sim/acps_host_clocks.sv
`timescale 1ns/100ps
// Host frame clock, locked to ref_clk and never stopped
module acps_host_clocks (
    input  wire  ref_clk,
    output logic frameTick = 1'b0
);
    logic [1:0] div = 2'h0;
    always @(posedge ref_clk) begin
        div       <= div + 2'h1;
        frameTick <= (div == 2'h3);
    end
endmodule // acps_host_clocks

// file: sim/acps_seq_checker.sv
`timescale 1ns/100ps
module acps_seq_checker (
    input wire       ref_clk, resetn, pllPower, masterSelect,
    input wire [1:0] clockMode,
    input wire       masterClockPresent, bitClockPresent, frameClockPresent,
    input wire       frameTick, levelControlAEnable, adcLeftPower,
    input wire       adcRightPower, pllLocked, masterClockOutValid,
    input wire       clocksOutEnable, normalOperation, adcInitBusy,
    input wire       adcDataZero, levelActive,
    input wire [7:0] initialVolume, levelGain
);
    logic [19:0] lockCnt = 20'h00000;
    logic [11:0] frames  = 12'h000;
    wire         bothOn  = adcLeftPower && adcRightPower;
    wire [19:0]  lockMin = (clockMode == 2'h1) ? 20'h04E20 : 20'h186A0;
    // Counted from power on, so a refused start can never pass early
    always @(posedge ref_clk) begin
        lockCnt <= (resetn && pllPower) ? lockCnt + 20'h00001 : 20'h00000;
        frames  <= (resetn && bothOn) ? frames + {11'h000, frameTick} : 12'h000;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence bothUp; $rose(bothOn); endsequence
    sequence levelOn; $rose(levelControlAEnable); endsequence
    a_reset_defaults: assert property (disable iff (1'b0) !resetn |=>
        !pllLocked && !levelActive && adcDataZero && levelGain == 8'h91)
        else $error("bad reset");
    a_lock_time: assert property ($rose(pllLocked) |->
        lockCnt >= lockMin && lockCnt <= lockMin + 20'h00003)
        else $error("bad lock time");
    a_clock_out_valid: assert property (masterClockOutValid |-> pllLocked)
        else $error("early clock");
    a_ext_clocks_needed: assert property ((clockMode == 2'h3 &&
        !masterSelect &&
        !(masterClockPresent && bitClockPresent && frameClockPresent)) [*2]
        |-> !normalOperation) else $error("runs without clocks");
    a_master_select_gate: assert property ((clockMode == 2'h3 &&
        !masterSelect) [*2] |-> !clocksOutEnable) else $error("clocks out");
    a_init_start: assert property (bothUp |=> adcInitBusy && adcDataZero)
        else $error("no init");
    a_init_length: assert property ($fell(adcInitBusy) && bothOn |->
        frames >= 12'h423 && frames <= 12'h424) else $error("bad init");
    a_level_start: assert property (levelOn |=> levelActive &&
        levelGain == $past(initialVolume)) else $error("bad gain");
endmodule // acps_seq_checker
bind acps_seq acps_seq_checker acps_seq_checker_inst (.*);

// file: sim/acps_seq_bench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_mismatch++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module acps_seq_bench;
    logic       ref_clk = 1'b0, resetn = 1'b0, clkEn = 1'b1;
    logic       masterSelect = 1'b0, commonRefPower = 1'b0, pllPower = 1'b0;
    logic       masterClockOutEnable = 1'b0, levelControlAEnable = 1'b0;
    logic       adcLeftPower = 1'b0, adcRightPower = 1'b0;
    logic [2:0] clkIn = 3'h0, r;
    logic [1:0] clockMode = 2'h1, adcInitCycleSelect = 2'h0;
    logic [7:0] initialVolume = 8'h00, v;
    wire        masterClockPresent = clkIn[2], bitClockPresent = clkIn[1];
    wire        frameClockPresent = clkIn[0];
    wire  [7:0] levelGain;
    wire        frameTick, pllLocked, masterClockOutValid, clocksOutEnable;
    wire        normalOperation, adcInitBusy, adcDataZero, levelActive;
    int         n_mismatch = 0, n_compared = 0, k, j;
    acps_seq acps_seq_inst (.*);
    acps_host_clocks acps_host_clocks_inst (.ref_clk(ref_clk),
        .frameTick(frameTick));
    initial forever #50 ref_clk = ~ref_clk;
    // Mode 3 gives {clocksOutEnable, normalOperation}
    function automatic logic [1:0] extExp(input logic [2:0] p, input logic m);
        return {m & p[2], p[2] & (m | (p[1] & p[0]))};
    endfunction
    task automatic edges(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #6000000;
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(27578));
        @(negedge ref_clk);
        `CHK("resetGain", 8'h91, levelGain)
        edges(2);
        resetn <= 1'b1;
        edges(1);
        commonRefPower <= 1'b1;
        clkIn <= 3'h2;
        pllPower <= 1'b1;
        k = 0;
        while (pllLocked !== 1'b1 && k < 20100) begin
            @(negedge ref_clk);
            k++;
        end
        `CHK("lockTime", 1'b1, k >= 20000 && k <= 20004)
        @(posedge ref_clk);
        pllPower <= 1'b0;
        clockMode <= 2'h2;
        masterClockOutEnable <= 1'b1;
        edges(2);
        pllPower <= 1'b1;
        edges(40);
        @(negedge ref_clk);
        `CHK("noRefLock", 2'h0, {pllLocked, masterClockOutValid})
        @(posedge ref_clk);
        pllPower <= 1'b0;
        adcLeftPower <= 1'b1;
        adcRightPower <= 1'b1;
        edges(3);
        masterClockOutEnable <= 1'b0;
        adcRightPower <= 1'b0;
        @(negedge ref_clk);
        `CHK("initOn", 2'h3, {adcInitBusy, adcDataZero})
        edges(3);
        adcRightPower <= 1'b1;
        @(negedge ref_clk);
        `CHK("abort", 1'b0, adcInitBusy)
        k = 0;
        j = 0;
        do begin
            @(negedge ref_clk);
            k += frameTick;
            j++;
        end while ((j < 3 || adcInitBusy === 1'b1) && j < 6000);
        @(negedge ref_clk);
        `CHK("initLen", 2'h2, {k >= 1059 && k <= 1060, adcDataZero})
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            @(posedge ref_clk);
            initialVolume <= v;
            levelControlAEnable <= 1'b1;
            repeat (2) @(negedge ref_clk);
            `CHK("startGain", {1'b1, v}, {levelActive, levelGain})
            @(posedge ref_clk);
            adcLeftPower <= (i < 5);
            levelControlAEnable <= 1'b0;
        end
        clockMode <= 2'h3;
        for (int i = 0; i < 8; i++) begin
            r = (i == 0) ? 3'h7 : 3'($urandom);
            @(posedge ref_clk);
            clkIn <= r;
            masterSelect <= (i == 0) | 1'($urandom);
            edges(3);
            @(negedge ref_clk);
            `CHK("extOuts", extExp(r, masterSelect),
                {clocksOutEnable, normalOperation})
        end
        @(posedge ref_clk);
        resetn <= 1'b0;
        edges(2);
        @(negedge ref_clk);
        `CHK("midReset", 3'h1, {pllLocked, levelActive, adcDataZero})
        tally_and_finish;
    end
endmodule // acps_seq_bench
